/* File: user_test_pattern_sequencer.sv */
/*
  user test pattern sequencer: replaces converter samples by four loaded
  patterns in user pattern mode, through a two-entry output buffer.
  assumes config inputs and samples come from logic on core_clk.
*/
// Notes on behaviour
// RULE_01: sequence bit only matters in user mode
// RULE_02: pattern n comes from byte pair n
// RULE_03: bit zero repeats patterns one to four
// RULE_04: single mode: four patterns, then zeros
// RULE_05: bit one selects single-sequence mode
// RULE_06: source 1000 user mode, 0000 samples
// RULE_07: eight byte registers 0x0551-0x0558, reset zero
`timescale 1ns/1ns
module user_test_pattern_sequencer
#(
  parameter int WORD_WIDTH = 16
)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // configuration
  input wire logic [3:0] testPatternSourceSelect,
  input wire logic userSequenceModeSelect,
  input wire logic cfgWrite,
  input wire logic [15:0] cfgAddr,
  input wire logic [7:0] cfgWrData,
  // converter samples
  input wire logic [WORD_WIDTH-1:0] sampleData,
  input wire logic sampleValid,
  output logic sampleReady,
  // output stream
  output logic [WORD_WIDTH-1:0] outData,
  output logic outValid,
  input wire logic outReady
);

  pattern_store_if storeBus ();

  user_pattern_pkg::seq_state_t state_q;
  logic [1:0] idx_q;
  logic userMode;
  logic singleMode;
  logic genValid;
  logic [WORD_WIDTH-1:0] genWord;
  logic push;
  logic pop;
  logic advance;
  logic [WORD_WIDTH-1:0] slot0_q;
  logic [WORD_WIDTH-1:0] slot1_q;
  logic [1:0] cnt_q;
  logic [1:0] cnt_d;
  logic [15:0] cfgOffset;

  pattern_store u_store
  (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .bus(storeBus)
  );

  // ----------------------------------------------------------------
  // pattern byte writes
  // ----------------------------------------------------------------
  assign cfgOffset = cfgAddr - user_pattern_pkg::PATTERN_FIRST_ADDR;
  assign storeBus.wrEn = cfgWrite
    && cfgAddr >= user_pattern_pkg::PATTERN_FIRST_ADDR
    && cfgAddr <= user_pattern_pkg::PATTERN_LAST_ADDR; // [RULE_07]
  assign storeBus.wrAddr = cfgOffset[2:0];
  assign storeBus.wrByte = cfgWrData;

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  // any code other than user mode passes samples; other generators live elsewhere
  assign userMode = testPatternSourceSelect == user_pattern_pkg::SRC_USER; // [RULE_06]
  // sequence bit is masked outside user mode
  assign singleMode = userMode
    && userSequenceModeSelect == user_pattern_pkg::SEQ_SINGLE; // [RULE_01] [RULE_05]

  // ----------------------------------------------------------------
  // word generation
  // ----------------------------------------------------------------
  always_comb
  begin
    if (userMode)
    begin
      genValid = 1'b1;
      genWord = (state_q == user_pattern_pkg::SEQ_DONE)
        ? '0 : WORD_WIDTH'(storeBus.rdWord); // [RULE_04]
    end
    else
    begin
      genValid = sampleValid;
      genWord = sampleData; // [RULE_06]
    end
  end

  assign push = genValid && cnt_q != user_pattern_pkg::BUF_DEPTH;
  assign pop = cnt_q != 2'h0 && outReady;
  assign advance = userMode && push && state_q != user_pattern_pkg::SEQ_DONE;
  // prefetch keeps rdWord aligned with idx_q
  assign storeBus.rdIdx = advance ? idx_q + 2'h1 : idx_q;

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_q <= user_pattern_pkg::SEQ_OFF;
      idx_q <= 2'h0;
    end
    else if (!userMode)
    begin
      state_q <= user_pattern_pkg::SEQ_OFF;
      idx_q <= 2'h0;
    end
    else
    begin
      unique case (state_q)
        user_pattern_pkg::SEQ_OFF,
        user_pattern_pkg::SEQ_RUN:
        begin
          state_q <= user_pattern_pkg::SEQ_RUN;
          if (advance)
          begin
            idx_q <= idx_q + 2'h1; // [RULE_03]
            if (idx_q == user_pattern_pkg::LAST_PATTERN_IDX && singleMode)
            begin
              state_q <= user_pattern_pkg::SEQ_DONE; // [RULE_04]
            end
          end
        end
        user_pattern_pkg::SEQ_DONE:
        begin
          // leaving single mode restarts the repeating order at pattern one
          if (!singleMode)
          begin
            state_q <= user_pattern_pkg::SEQ_RUN; // [RULE_03]
            idx_q <= 2'h0;
          end
        end
        default:
        begin
          state_q <= user_pattern_pkg::SEQ_OFF;
          idx_q <= 2'h0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // two-entry output buffer
  // ----------------------------------------------------------------
  always_comb
  begin
    cnt_d = cnt_q;
    if (push && !pop)
    begin
      cnt_d = cnt_q + 2'h1;
    end
    else if (pop && !push)
    begin
      cnt_d = cnt_q - 2'h1;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      slot0_q <= '0;
      slot1_q <= '0;
      cnt_q <= 2'h0;
    end
    else
    begin
      cnt_q <= cnt_d;
      if (pop)
      begin
        slot0_q <= (cnt_q == 2'h1) ? genWord : slot1_q;
        if (push && cnt_q == 2'h2)
        begin
          slot1_q <= genWord;
        end
        else if (push)
        begin
          slot1_q <= slot1_q;
        end
        if (push && cnt_q == 2'h2)
        begin
          slot0_q <= slot1_q;
        end
      end
      else if (push)
      begin
        if (cnt_q == 2'h0)
        begin
          slot0_q <= genWord;
        end
        else
        begin
          slot1_q <= genWord;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // registered handshake outputs
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      outValid <= 1'b0;
      sampleReady <= 1'b0;
    end
    else
    begin
      outValid <= cnt_d != 2'h0;
      // samples are drained and dropped while patterns replace them
      sampleReady <= cnt_d != user_pattern_pkg::BUF_DEPTH;
    end
  end

  assign outData = slot0_q;

endmodule : user_test_pattern_sequencer

/* File: user_pattern_pkg.sv */
/*
  constants shared by the user test pattern sequencer and its pattern store.
  assumes nothing of its surroundings.
*/
package user_pattern_pkg;

  // ----------------------------------------------------------------
  // test pattern source select codes
  // ----------------------------------------------------------------
  localparam logic [3:0] SRC_NORMAL = 4'h0;
  localparam logic [3:0] SRC_USER = 4'h8;

  // ----------------------------------------------------------------
  // user sequence mode select values
  // ----------------------------------------------------------------
  localparam logic SEQ_REPEAT = 1'b0;
  localparam logic SEQ_SINGLE = 1'b1;

  // ----------------------------------------------------------------
  // pattern byte map (low byte first per pattern)
  // ----------------------------------------------------------------
  localparam logic [15:0] PATTERN_FIRST_ADDR = 16'h0551;
  localparam logic [15:0] PATTERN_LAST_ADDR = 16'h0558;
  localparam logic [7:0] PATTERN_BYTE_RESET = 8'h00;
  localparam int PATTERN_COUNT = 4;
  localparam int PATTERN_BYTES = 2 * PATTERN_COUNT;
  localparam logic [1:0] LAST_PATTERN_IDX = 2'h3;

  // ----------------------------------------------------------------
  // output buffer
  // ----------------------------------------------------------------
  localparam logic [1:0] BUF_DEPTH = 2'h2;

  typedef enum logic [1:0]
  {
    SEQ_OFF = 2'b00,
    SEQ_RUN = 2'b01,
    SEQ_DONE = 2'b10
  } seq_state_t;

endpackage : user_pattern_pkg

/* File: pattern_store_if.sv */
/*
  carrier between the sequencer and its pattern store.
  assumes both ends run on the same clock.
*/
`timescale 1ns/1ns
interface pattern_store_if;
  logic wrEn;
  logic [2:0] wrAddr;
  logic [7:0] wrByte;
  logic [1:0] rdIdx;
  logic [15:0] rdWord;

  modport store
  (
    input wrEn,
    input wrAddr,
    input wrByte,
    input rdIdx,
    output rdWord
  );

  modport user
  (
    output wrEn,
    output wrAddr,
    output wrByte,
    output rdIdx,
    input rdWord
  );
endinterface : pattern_store_if

/* File: pattern_store.sv */
/*
  eight byte registers holding the four user patterns, registered read.
  assumes writes and reads come from logic on core_clk.
*/
`timescale 1ns/1ns
module pattern_store
(
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // access
  pattern_store_if.store bus
);

  logic [7:0] byte_q [user_pattern_pkg::PATTERN_BYTES];
  logic [15:0] rdWord_q;

  // ----------------------------------------------------------------
  // byte storage
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < user_pattern_pkg::PATTERN_BYTES; i++)
      begin
        byte_q[i] <= user_pattern_pkg::PATTERN_BYTE_RESET; // [RULE_07]
      end
    end
    else if (bus.wrEn)
    begin
      byte_q[bus.wrAddr] <= bus.wrByte; // [RULE_07]
    end
  end

  // ----------------------------------------------------------------
  // read port: pattern n is always pair n
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rdWord_q <= 16'h0000;
    end
    else
    begin
      rdWord_q <= {byte_q[{bus.rdIdx, 1'b1}], byte_q[{bus.rdIdx, 1'b0}]}; // [RULE_02]
    end
  end

  assign bus.rdWord = rdWord_q;

endmodule : pattern_store

/* File: seq_asserts.sv */
/* port checker for the user pattern sequencer, bound to its top module.
   assumes the output is drained before user mode is entered. */
`timescale 1ns/1ns
module seq_asserts
#(
  parameter int WORD_WIDTH = 16
)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // configuration
  input wire logic [3:0] testPatternSourceSelect,
  input wire logic userSequenceModeSelect,
  input wire logic cfgWrite,
  input wire logic [15:0] cfgAddr,
  input wire logic [7:0] cfgWrData,
  // streams
  input wire logic [WORD_WIDTH-1:0] sampleData,
  input wire logic sampleValid,
  input wire logic sampleReady,
  input wire logic [WORD_WIDTH-1:0] outData,
  input wire logic outValid,
  input wire logic outReady
);
  // ----
  // shadow of pattern bytes and words sent
  // ----
  logic [7:0] byte_q [user_pattern_pkg::PATTERN_BYTES];
  logic wrote_q;
  logic [15:0] sent_q;
  logic user;
  logic single;
  logic [15:0] expWord;
  assign user = testPatternSourceSelect == user_pattern_pkg::SRC_USER;
  assign single = userSequenceModeSelect == user_pattern_pkg::SEQ_SINGLE;
  assign expWord = {byte_q[{sent_q[1:0], 1'b1}], byte_q[{sent_q[1:0], 1'b0}]};
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      byte_q <= '{default: 8'h00};
      wrote_q <= 1'b0;
    end
    else if (cfgWrite && cfgAddr >= user_pattern_pkg::PATTERN_FIRST_ADDR
      && cfgAddr <= user_pattern_pkg::PATTERN_LAST_ADDR)
    begin
      byte_q[3'(cfgAddr - user_pattern_pkg::PATTERN_FIRST_ADDR)] <= cfgWrData;
      wrote_q <= 1'b1;
    end
  end
  // leaving user mode restarts the count at pattern one
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      sent_q <= 16'h0000;
    else if (!user)
      sent_q <= 16'h0000;
    else if (outValid && outReady)
      sent_q <= sent_q + 16'h0001;
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  sequence s_take;
    sampleValid && sampleReady && !outValid;
  endsequence
  sequence s_word_out;
    ##1 outValid && outData == $past(sampleData);
  endsequence
  a_sample_pass: assert property (
    (testPatternSourceSelect == user_pattern_pkg::SRC_NORMAL) ##0 s_take |-> s_word_out)
    else $error("sample lost");
  a_user_fill: assert property (
    $rose(user) |=> outValid [*2]) else $error("user mode gave no words");
  a_bit_ignored: assert property (
    (!user && single) ##0 s_take |-> s_word_out) else $error("mode bit not ignored");
  a_repeat_order: assert property (
    user && !single && outValid |-> outData == expWord) else $error("repeat order wrong");
  a_single_pass: assert property (
    user && single && outValid && sent_q < 16'h0004 |-> outData == expWord)
    else $error("single pass wrong");
  a_single_zero: assert property (
    user && single && outValid && sent_q >= 16'h0004 |-> outData == '0)
    else $error("no zeros after pass");
  a_reset_zero: assert property (
    user && !wrote_q && outValid |-> outData == '0) else $error("pattern not reset");
endmodule : seq_asserts
bind user_test_pattern_sequencer seq_asserts #(.WORD_WIDTH(WORD_WIDTH)) chk (.core_clk,
  .sys_rst, .testPatternSourceSelect, .userSequenceModeSelect, .cfgWrite, .cfgAddr,
  .cfgWrData, .sampleData, .sampleValid, .sampleReady, .outData, .outValid, .outReady);

/* File: sink_model.sv */
/* receiving logic: takes words on valid and ready, may stall.
   assumes the bench pops the received queue. */
`timescale 1ns/1ns
module sink_model
(
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // stream
  input wire logic [15:0] outData,
  input wire logic outValid,
  input wire logic slow,
  output logic outReady
);
  logic [15:0] words [$];
  logic [1:0] phase_q;
  always @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      outReady <= 1'b0;
      phase_q <= 2'h0;
    end
    else
    begin
      if (outValid && outReady)
        words.push_back(outData);
      phase_q <= phase_q + 2'h1;
      // slow: ready one cycle in four, so the buffer fills
      outReady <= !slow || phase_q == 2'h3;
    end
  end
endmodule : sink_model

/* File: testbench.sv */
/* self-checking bench for the user pattern sequencer.
   assumes the sink model collects every word that leaves. */
`timescale 1ns/1ns
module testbench;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] src = 4'h0;
  logic seq = 1'b0;
  logic cfgWrite = 1'b0;
  logic [15:0] cfgAddr = 16'h0000;
  logic [7:0] cfgWrData = 8'h00;
  logic [15:0] sampleData = 16'h0000;
  logic sampleValid = 1'b0;
  logic slow = 1'b0;
  logic sampleReady;
  logic outValid;
  logic outReady;
  logic [15:0] outData;
  logic [15:0] pat [4] = '{16'h2211, 16'h4433, 16'h6655, 16'h8877};
  int fails = 0;
  int compares = 0;
  always #20 core_clk = ~core_clk;
  user_test_pattern_sequencer uut (.core_clk, .sys_rst, .testPatternSourceSelect(src),
    .userSequenceModeSelect(seq), .cfgWrite, .cfgAddr, .cfgWrData, .sampleData,
    .sampleValid, .sampleReady, .outData, .outValid, .outReady);
  sink_model sink (.core_clk, .sys_rst, .outData, .outValid, .slow, .outReady);
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask : tick
  task automatic expect_word(input logic [15:0] exp);
    for (int w = 0; w < 60 && sink.words.size() == 0; w++)
      tick(1);
    check(sink.words.size() > 0 ? sink.words.pop_front() : 16'hxxxx, exp);
  endtask : expect_word
  // drains the buffer in normal mode so each scenario starts empty
  task automatic set_mode(input logic [3:0] s, input logic m);
    src = 4'h0;
    slow = 1'b0;
    tick(8);
    sink.words.delete();
    seq = m;
    src = s;
  endtask : set_mode
  task automatic send(input int n);
    logic rdy;
    for (int i = 0; i < n; i++)
    begin
      sampleData = 16'ha500 + 16'(i);
      sampleValid = 1'b1;
      rdy = 1'b0;
      for (int w = 0; w < 40 && !rdy; w++)
      begin
        rdy = sampleReady === 1'b1;
        tick(1);
      end
      check(16'(rdy), 16'h0001);
    end
    sampleValid = 1'b0;
  endtask : send
  task automatic t_zero;
    set_mode(user_pattern_pkg::SRC_USER, user_pattern_pkg::SEQ_REPEAT);
    repeat (4)
      expect_word(16'h0000);
    $display("reset pattern test done");
  endtask : t_zero
  task automatic t_load;
    set_mode(4'h0, user_pattern_pkg::SEQ_REPEAT);
    cfgWrite = 1'b1;
    // the two neighbours of the pattern bytes must be ignored
    for (int k = 0; k < 10; k++)
    begin
      cfgAddr = 16'h0550 + 16'(k);
      cfgWrData = (k == 0 || k == 9) ? 8'hff : 8'h11 * 8'(k);
      tick(1);
    end
    cfgWrite = 1'b0;
    set_mode(user_pattern_pkg::SRC_USER, user_pattern_pkg::SEQ_REPEAT);
    expect_word(pat[0]);
    $display("load test done");
  endtask : t_load
  task automatic t_repeat;
    set_mode(user_pattern_pkg::SRC_USER, user_pattern_pkg::SEQ_REPEAT);
    slow = 1'b1;
    for (int i = 0; i < 10; i++)
      expect_word(pat[i % 4]);
    $display("repeat test done");
  endtask : t_repeat
  task automatic t_single;
    set_mode(user_pattern_pkg::SRC_USER, user_pattern_pkg::SEQ_SINGLE);
    slow = 1'b1;
    for (int i = 0; i < 8; i++)
      expect_word(i < 4 ? pat[i] : 16'h0000);
    $display("single test done");
  endtask : t_single
  task automatic t_samples(input logic [3:0] s);
    set_mode(s, user_pattern_pkg::SEQ_SINGLE);
    slow = 1'b1;
    send(5);
    for (int i = 0; i < 5; i++)
      expect_word(16'ha500 + 16'(i));
    $display("sample test done");
  endtask : t_samples
  task automatic end_of_test;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_of_test
  initial
  begin
    tick(3);
    sys_rst = 1'b0;
    tick(1);
    t_zero();
    t_load();
    t_repeat();
    t_single();
    t_samples(4'h0);
    t_samples(4'h1);
    end_of_test();
  end
  // all tests take well under 400 cycles
  initial
  begin
    #(40 * 3000);
    fails++;
    end_of_test();
  end
endmodule : testbench
